// *** rtl/pwm_pkg.sv ***
package pwm_pkg;
   // ==========================================
   // widths
   localparam int AVG_W = 13;
   localparam int SUM_W = 20;
   localparam int MM_W = 11;
   localparam int ADC_W = 10;
   localparam int DIV_W = 14;
   localparam int DUTY_W = 19;
   localparam int CNT_W = 23;
   localparam int SMP_W = 9;
   localparam int DIFF_W = 12;
   localparam int SPAN_W = 4;
   localparam int HIST_D = 8;
   // ==========================================
   // reset values and limits
   localparam logic [DIV_W-1:0] DIV_MIN = 14'h004f;
   localparam logic [DIV_W-1:0] DIV_RESET = 14'h0271;
   localparam logic [1:0] SMP_SEL_RESET = 2'h0;
   // ==========================================
   // samples per period codes
   localparam logic [1:0] SMP_32 = 2'h0;
   localparam logic [1:0] SMP_64 = 2'h1;
   localparam logic [1:0] SMP_128 = 2'h2;
   localparam logic [1:0] SMP_512 = 2'h3;
   // ==========================================
   // profile zones
   typedef enum logic [3:0] {
      Z_IDLE = 4'h1,
      Z_ONE = 4'h2,
      Z_TWO = 4'h4,
      Z_THREE = 4'h8
   } zone_t;
   // ==========================================
   // last sample index of a period
   function automatic logic [SMP_W-1:0] samples_last(input logic [1:0] sel);
      case (sel)
         SMP_64: samples_last = 9'h03f;
         SMP_128: samples_last = 9'h07f;
         SMP_512: samples_last = 9'h1ff;
         default: samples_last = 9'h01f;
      endcase
   endfunction
   // on-time scale m/32 as a left shift
   function automatic logic [2:0] samples_shift(input logic [1:0] sel);
      case (sel)
         SMP_64: samples_shift = 3'h1;
         SMP_128: samples_shift = 3'h2;
         SMP_512: samples_shift = 3'h4;
         default: samples_shift = 3'h0;
      endcase
   endfunction
endpackage

// *** rtl/sample_history.sv ***
`timescale 1ns/1ps
module sample_history
   import pwm_pkg::*;
#(
   parameter int DEPTH = HIST_D
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // samples
   input wire logic clear,
   input wire logic push,
   input wire logic [ADC_W-1:0] sample,
   // difference
   input wire logic [SPAN_W-1:0] span,
   output logic signed [DIFF_W-1:0] diff,
   output logic ready
);
   // ==========================================
   // history of older samples, hist[0] newest
   logic [ADC_W-1:0] hist [DEPTH];
   logic [SPAN_W-1:0] fill_r;
   logic [SPAN_W-1:0] idx;

   always_ff @(posedge clk) begin
      if (push) begin
         hist[0] <= sample;
      end
   end

   genvar g;
   generate
      for (g = 1; g < DEPTH; g++) begin : g_shift
         always_ff @(posedge clk) begin
            if (push) begin
               hist[g] <= hist[g-1];
            end
         end
      end
   endgenerate

   // fill restarts so stale samples from an earlier pulse never count
   always_ff @(posedge clk) begin
      if (reset || clear) begin
         fill_r <= 4'h0;
      end else if (push && fill_r != SPAN_W'(DEPTH)) begin
         fill_r <= fill_r + 4'h1;
      end
   end

   assign idx = (span == 4'h0) ? 4'h0 : span - 4'h1;
   assign ready = (span != 4'h0) && (fill_r >= span);
   assign diff = $signed({2'h0, sample}) - $signed({2'h0, hist[idx[2:0]]});
endmodule

// *** rtl/feedback_track.sv ***
`timescale 1ns/1ps
module feedback_track
   import pwm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // per-cycle averages of the selected channel
   input wire logic restart,
   input wire logic cycle_done,
   input wire logic dither_start,
   input wire logic dither_off,
   input wire logic [AVG_W-1:0] cycle_avg,
   // accesses
   input wire logic avg_access,
   input wire logic minmax_access,
   // results
   output logic [SUM_W-1:0] avg_sum,
   output logic avg_valid,
   output logic [MM_W-1:0] min_cur,
   output logic [MM_W-1:0] max_cur,
   output logic minmax_valid
);
   // ==========================================
   // period accumulation
   logic run_r;
   logic [SUM_W-1:0] acc_r;
   logic [AVG_W-1:0] min_r;
   logic [AVG_W-1:0] max_r;
   logic close_w;
   logic store_w;
   logic [AVG_W-1:0] min_nxt;
   logic [AVG_W-1:0] max_nxt;

   assign close_w = cycle_done && dither_start && run_r;
   assign store_w = (cycle_done && dither_off) || close_w;
   assign min_nxt = (cycle_avg < min_r) ? cycle_avg : min_r;
   assign max_nxt = (cycle_avg > max_r) ? cycle_avg : max_r;

   always_ff @(posedge clk) begin
      if (reset || restart) begin
         run_r <= 1'b0; // [RQ8]
         acc_r <= 20'h00000;
         min_r <= 13'h1fff;
         max_r <= 13'h0000;
      end else if (cycle_done && (dither_start || dither_off)) begin
         run_r <= 1'b1; // [RQ7]
         acc_r <= SUM_W'(cycle_avg); // [RQ1]
         min_r <= cycle_avg;
         max_r <= cycle_avg;
      end else if (cycle_done && run_r) begin
         acc_r <= acc_r + SUM_W'(cycle_avg); // [RQ1]
         min_r <= min_nxt; // [RQ2]
         max_r <= max_nxt;
      end
   end

   // ==========================================
   // stored results, dither off refreshes every period
   always_ff @(posedge clk) begin
      if (reset) begin
         avg_sum <= 20'h00000;
         min_cur <= 11'h000;
         max_cur <= 11'h000;
      end else if (cycle_done && dither_off) begin
         avg_sum <= SUM_W'(cycle_avg); // [RQ3]
         min_cur <= cycle_avg[AVG_W-1:2]; // [RQ4]
         max_cur <= cycle_avg[AVG_W-1:2];
      end else if (close_w) begin
         avg_sum <= acc_r;
         min_cur <= min_r[AVG_W-1:2]; // [RQ2]
         max_cur <= max_r[AVG_W-1:2];
      end
   end

   // set wins over the access clear
   always_ff @(posedge clk) begin
      if (reset) begin
         avg_valid <= 1'b0;
         minmax_valid <= 1'b0;
      end else begin
         avg_valid <= store_w || (avg_valid && !avg_access); // [RQ5]
         minmax_valid <= store_w || (minmax_valid && !minmax_access); // [RQ6]
      end
   end
endmodule

// *** rtl/direct_pwm_profile_detect_feedback.sv ***
`timescale 1ns/1ps
// Operation
// (RQ1) sum 13-bit cycle averages over a dither period into 20 bits
// (RQ2) keep upper 11 bits of period minimum and maximum
// (RQ3) dither off: sum refreshes each period, equals cycle feedback
// (RQ4) dither off: min and max refresh each period, upper 11 bits
// (RQ5) average access clears its valid; a stored sum sets it
// (RQ6) min/max access clears its valid; a finished period sets it
// (RQ7) tracking runs on last selected channel continuously
// (RQ8) new channel waits for next dither period start
// (RQ9) one channel selection serves both feedback messages
// (RQ10) direct mode disables loop, integrator cleared and held at 0
// (RQ11) pwm period is samples times divider clocks
// (RQ12) divider below 79 becomes 79 and reads back 79
// (RQ13) divider is a 14-bit field
// (RQ14) new divider reads back at once, applies next period; default 625
// (RQ15) samples per period 32, 64, 128 or 512, default 32
// (RQ16) host keeps pwm rate times samples at most 128 kHz
// (RQ17) on-time is duty times samples over 32 clocks, clipped at 100%
// (RQ18) profile check only in direct mode, full 10-bit samples
// (RQ19) rising output enters zone 1, rising slope hits within count+1
// (RQ20) zone 2 counts slope below limit; zero limit needs falling slope
// (RQ21) zone 3 spans 1 to 4 samples; its hits pass the profile
// (RQ22) after one miss, compare double span against double limit
// (RQ23) timeout before all zones pass sets timeout status
// (RQ24) falling output before completion sets interrupted status
// (RQ25) all zones passed sets passed status
// (RQ26) each rising output resets zone state and counters
module direct_pwm_profile_detect_feedback
   import pwm_pkg::*;
#(
   parameter int HIT_W = 4,
   parameter int TMO_W = 16,
   parameter int DSTEP_W = 4,
   parameter int DAMP_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // channel selection and message accesses
   input wire logic sel_wr,
   input wire logic [2:0] sel_chan,
   input wire logic avg_access,
   input wire logic minmax_access,
   // per-cycle current averages of all channels
   input wire logic [2:0] fb_chan,
   input wire logic fb_cycle_done,
   input wire logic fb_dither_start,
   input wire logic [AVG_W-1:0] fb_cycle_avg,
   input wire logic [DSTEP_W-1:0] dither_steps,
   input wire logic [DAMP_W-1:0] dither_amp,
   // feedback results
   output logic [2:0] sel_chan_rd,
   output logic [SUM_W-1:0] avg_sum,
   output logic avg_valid,
   output logic [MM_W-1:0] min_cur,
   output logic [MM_W-1:0] max_cur,
   output logic minmax_valid,
   // direct pwm settings
   input wire logic direct_mode,
   input wire logic div_wr,
   input wire logic [DIV_W-1:0] div_in,
   input wire logic [1:0] samples_sel,
   input wire logic [DUTY_W-1:0] duty_in,
   input wire logic pi_gate,
   // pwm outputs
   output logic [DIV_W-1:0] div_rd,
   output logic gate_drive_output,
   output logic integ_clear,
   output logic period_start,
   output logic adc_start,
   // profile check settings
   input wire logic adc_valid,
   input wire logic [ADC_W-1:0] adc_data,
   input wire logic [ADC_W-1:0] zone1_slope_limit,
   input wire logic [ADC_W-1:0] zone2_slope_limit,
   input wire logic [ADC_W-1:0] zone3_slope_limit,
   input wire logic [HIT_W-1:0] zone1_required_hits,
   input wire logic [HIT_W-1:0] zone2_required_hits,
   input wire logic [HIT_W-1:0] zone3_required_hits,
   input wire logic [1:0] zone3_span,
   input wire logic [TMO_W-1:0] profile_timeout,
   input wire logic status_read,
   // profile check status
   output logic [3:0] profile_zone,
   output logic profile_passed,
   output logic profile_timed_out,
   output logic profile_interrupted
);
   // ==========================================
   // channel selection
   logic sel_change;
   logic fb_hit;
   logic dither_off;

   assign sel_change = sel_wr && (sel_chan != sel_chan_rd);
   assign fb_hit = (fb_chan == sel_chan_rd) && !sel_change;
   assign dither_off = (dither_steps == '0) || (dither_amp == '0);

   // both messages write this one register
   always_ff @(posedge clk) begin
      if (reset) begin
         sel_chan_rd <= 3'h0;
      end else if (sel_wr) begin
         sel_chan_rd <= sel_chan; // [RQ9]
      end
   end

   feedback_track u_track (
      .clk(clk),
      .reset(reset),
      .restart(sel_change), // [RQ8]
      .cycle_done(fb_cycle_done && fb_hit), // [RQ7]
      .dither_start(fb_dither_start),
      .dither_off(dither_off),
      .cycle_avg(fb_cycle_avg),
      .avg_access(avg_access),
      .minmax_access(minmax_access),
      .avg_sum(avg_sum),
      .avg_valid(avg_valid),
      .min_cur(min_cur),
      .max_cur(max_cur),
      .minmax_valid(minmax_valid)
   );

   // ==========================================
   // divider and sample count
   logic [DIV_W-1:0] div_act_r;
   logic [1:0] smp_sel_r;
   logic [DIV_W-1:0] slot_r;
   logic [SMP_W-1:0] smp_r;
   logic [CNT_W-1:0] elapsed_r;
   logic slot_end;
   logic period_end;
   logic [CNT_W-1:0] on_time;
   logic pwm_on;

   // a written divider is visible at once, used from the next period
   always_ff @(posedge clk) begin
      if (reset) begin
         div_rd <= DIV_RESET; // [RQ14]
      end else if (div_wr) begin
         div_rd <= (div_in < DIV_MIN) ? DIV_MIN : div_in; // [RQ12] [RQ13]
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         div_act_r <= DIV_RESET;
         smp_sel_r <= SMP_SEL_RESET; // [RQ15]
      end else if (period_end) begin
         div_act_r <= div_rd; // [RQ14]
         smp_sel_r <= samples_sel;
      end
   end

   assign slot_end = (slot_r == div_act_r - 14'h0001);
   assign period_end = slot_end && (smp_r == samples_last(smp_sel_r)); // [RQ11]

   always_ff @(posedge clk) begin
      if (reset || period_end) begin
         slot_r <= 14'h0000;
         smp_r <= 9'h000;
         elapsed_r <= 23'h000000;
      end else begin
         slot_r <= slot_end ? 14'h0000 : slot_r + 14'h0001; // [RQ11]
         smp_r <= slot_end ? smp_r + 9'h001 : smp_r;
         elapsed_r <= elapsed_r + 23'h000001;
      end
   end

   // a duty past the period keeps the output on the whole period
   assign on_time = CNT_W'({4'h0, duty_in} << samples_shift(smp_sel_r)); // [RQ17]
   assign pwm_on = (elapsed_r < on_time); // [RQ17]

   always_ff @(posedge clk) begin
      if (reset) begin
         gate_drive_output <= 1'b0;
         integ_clear <= 1'b0;
         period_start <= 1'b0;
         adc_start <= 1'b0;
      end else begin
         gate_drive_output <= direct_mode ? pwm_on : pi_gate; // [RQ10]
         integ_clear <= direct_mode; // [RQ10]
         period_start <= period_end;
         adc_start <= slot_end; // [RQ11]
      end
   end

   // ==========================================
   // profile check edges and history
   zone_t zone_r;
   logic gate_prev_r;
   logic rise;
   logic fall;
   logic active;
   logic [HIT_W-1:0] hits_r;
   logic miss_r;
   logic miss_used_r;
   logic [TMO_W-1:0] tmo_r;
   logic [SPAN_W-1:0] base_span;
   logic [SPAN_W-1:0] span;
   logic signed [DIFF_W-1:0] diff;
   logic hist_ready;

   assign rise = gate_drive_output && !gate_prev_r && direct_mode; // [RQ19]
   assign fall = !gate_drive_output && gate_prev_r;
   assign active = (zone_r != Z_IDLE);

   always_ff @(posedge clk) begin
      if (reset) begin
         gate_prev_r <= 1'b0;
      end else begin
         gate_prev_r <= gate_drive_output;
      end
   end

   assign base_span = (zone_r == Z_THREE) ? {2'h0, zone3_span} + 4'h1 : 4'h1; // [RQ21]
   assign span = miss_r ? base_span << 1 : base_span; // [RQ22]

   sample_history #(
      .DEPTH(HIST_D)
   ) u_hist (
      .clk(clk),
      .reset(reset),
      .clear(rise), // [RQ26]
      .push(adc_valid),
      .sample(adc_data), // [RQ18]
      .span(span),
      .diff(diff),
      .ready(hist_ready)
   );

   // ==========================================
   // zone comparison
   logic [ADC_W-1:0] limit;
   logic signed [DIFF_W-1:0] limit_eff;
   logic [HIT_W-1:0] need;
   logic hit;
   logic cmp_go;
   logic zone_done;
   logic timed_out;
   logic passed_ev;
   logic interrupted_ev;

   assign limit = (zone_r == Z_ONE) ? zone1_slope_limit :
                  (zone_r == Z_TWO) ? zone2_slope_limit : zone3_slope_limit;
   assign need = (zone_r == Z_ONE) ? zone1_required_hits :
                 (zone_r == Z_TWO) ? zone2_required_hits : zone3_required_hits;
   assign limit_eff = miss_r ? $signed({1'b0, limit, 1'b0}) :
                               $signed({2'h0, limit}); // [RQ22]
   // a zero zone 2 limit only passes a falling slope
   assign hit = (zone_r == Z_TWO) ? (diff < limit_eff) : (diff > limit_eff); // [RQ20]
   assign cmp_go = active && adc_valid && hist_ready && direct_mode; // [RQ18]
   assign zone_done = cmp_go && hit && (hits_r + 1'b1 >= need);
   assign timed_out = active && (tmo_r >= profile_timeout);
   assign passed_ev = zone_done && (zone_r == Z_THREE) && !timed_out;
   assign interrupted_ev = active && fall && !timed_out;

   always_ff @(posedge clk) begin
      if (reset) begin
         zone_r <= Z_IDLE;
      end else if (rise) begin
         zone_r <= Z_ONE; // [RQ19] [RQ26]
      end else if (!direct_mode || timed_out || fall) begin
         zone_r <= Z_IDLE; // [RQ23] [RQ24]
      end else if (zone_done) begin
         case (zone_r)
            Z_ONE: zone_r <= Z_TWO; // [RQ19]
            Z_TWO: zone_r <= Z_THREE; // [RQ20]
            default: zone_r <= Z_IDLE; // [RQ21]
         endcase
      end
   end

   // one miss per zone is forgiven; each later miss restarts the window
   always_ff @(posedge clk) begin
      if (reset || rise || zone_done) begin
         hits_r <= '0; // [RQ26]
         miss_r <= 1'b0;
         miss_used_r <= 1'b0;
      end else if (cmp_go && hit) begin
         hits_r <= hits_r + 1'b1; // [RQ19]
         miss_r <= 1'b0;
      end else if (cmp_go) begin
         hits_r <= miss_used_r ? '0 : hits_r;
         miss_r <= 1'b1; // [RQ22]
         miss_used_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || rise || !active) begin
         tmo_r <= '0; // [RQ26]
      end else if (tmo_r != '1) begin
         tmo_r <= tmo_r + 1'b1; // [RQ23]
      end
   end

   // ==========================================
   // sticky status, an event wins over the read clear
   always_ff @(posedge clk) begin
      if (reset) begin
         profile_passed <= 1'b0;
         profile_timed_out <= 1'b0;
         profile_interrupted <= 1'b0;
         profile_zone <= 4'h1;
      end else begin
         profile_passed <= passed_ev || (profile_passed && !status_read); // [RQ25]
         profile_timed_out <= timed_out || (profile_timed_out && !status_read); // [RQ23]
         profile_interrupted <= interrupted_ev ||
                                (profile_interrupted && !status_read); // [RQ24]
         profile_zone <= zone_r;
      end
   end
endmodule

// *** tb/pwm_monitor.sv ***
`timescale 1ns/1ps
// ==========================================
// port checker for feedback, pwm and profile status
module pwm_monitor
   import pwm_pkg::*;
#(
   parameter int DSTEP_W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // selection and feedback
   input wire logic sel_wr,
   input wire logic [2:0] sel_chan,
   input wire logic [2:0] sel_chan_rd,
   input wire logic avg_access,
   input wire logic minmax_access,
   input wire logic [2:0] fb_chan,
   input wire logic fb_cycle_done,
   input wire logic [AVG_W-1:0] fb_cycle_avg,
   input wire logic [DSTEP_W-1:0] dither_steps,
   input wire logic [SUM_W-1:0] avg_sum,
   input wire logic avg_valid,
   input wire logic [MM_W-1:0] min_cur,
   input wire logic [MM_W-1:0] max_cur,
   input wire logic minmax_valid,
   // pwm and profile
   input wire logic direct_mode,
   input wire logic div_wr,
   input wire logic [DIV_W-1:0] div_in,
   input wire logic [DIV_W-1:0] div_rd,
   input wire logic gate_drive_output,
   input wire logic integ_clear,
   input wire logic [3:0] profile_zone,
   input wire logic profile_passed
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // skip reports during a selection write
   wire fb_hit = fb_cycle_done && fb_chan == sel_chan_rd && !sel_wr;

   a_sel_readback: assert property (sel_wr |=> sel_chan_rd == $past(sel_chan))
      else $error("selection readback wrong");
   a_div_clamp: assert property (div_wr && div_in < DIV_MIN |=> div_rd == DIV_MIN)
      else $error("divider not clamped");
   a_div_readback: assert property (div_wr && div_in >= DIV_MIN |=> div_rd == $past(div_in))
      else $error("divider readback wrong");
   a_integ_hold: assert property ($stable(direct_mode) |-> integ_clear == direct_mode)
      else $error("integrator clear does not follow mode");
   a_avg_clear: assert property (avg_access && !fb_cycle_done |=> !avg_valid)
      else $error("average valid not cleared");
   a_avg_set: assert property ($rose(avg_valid) |-> $past(fb_hit))
      else $error("average valid set without a report");
   a_mm_clear: assert property (minmax_access && !fb_cycle_done |=> !minmax_valid)
      else $error("minmax valid not cleared");
   a_mm_order: assert property (minmax_valid |-> min_cur <= max_cur)
      else $error("minimum above maximum");
   a_off_sum: assert property (fb_hit && dither_steps == '0 |=> avg_sum == SUM_W'($past(fb_cycle_avg)))
      else $error("undithered sum wrong");
   a_off_minmax: assert property (fb_hit && dither_steps == '0 |=>
      min_cur == MM_W'($past(fb_cycle_avg) >> 2) && max_cur == MM_W'($past(fb_cycle_avg) >> 2))
      else $error("undithered min max wrong");
   a_idle_zone: assert property (!direct_mode ##1 !direct_mode |=> profile_zone == 4'h1)
      else $error("profile active outside direct mode");
   a_zone_entry: assert property ($rose(gate_drive_output) && direct_mode ##1 direct_mode
      |-> ##[0:2] profile_zone == 4'h2)
      else $error("rising output did not enter zone one");
   a_pass_zone: assert property ($rose(profile_passed)
      |-> $past(profile_zone) == 4'h8 || $past(profile_zone, 2) == 4'h8)
      else $error("pass without zone three");

   cover property ($rose(profile_passed));
   cover property ($rose(avg_valid) && dither_steps != '0);
   cover property (div_wr && div_in < DIV_MIN);
endmodule

bind direct_pwm_profile_detect_feedback pwm_monitor #(.DSTEP_W(DSTEP_W)) i_mon (.clk, .reset,
   .sel_wr, .sel_chan, .sel_chan_rd, .avg_access, .minmax_access, .fb_chan, .fb_cycle_done,
   .fb_cycle_avg, .dither_steps, .avg_sum, .avg_valid, .min_cur, .max_cur, .minmax_valid,
   .direct_mode, .div_wr, .div_in, .div_rd, .gate_drive_output, .integ_clear, .profile_zone,
   .profile_passed);

// *** tb/fb_source.sv ***
`timescale 1ns/1ps
// ==========================================
// current loop side: per-cycle average reports
module fb_source
   import pwm_pkg::*;
(
   // clock
   input wire logic clk,
   // reports
   output logic [2:0] fb_chan,
   output logic fb_cycle_done,
   output logic fb_dither_start,
   output logic [AVG_W-1:0] fb_cycle_avg
);
   initial begin
      fb_chan = 3'h0;
      fb_cycle_done = 1'b0;
      fb_dither_start = 1'b0;
      fb_cycle_avg = '0;
   end
   // lines invert after the pulse so a stale value can never pass as fresh
   task automatic send(input logic [2:0] c, input logic s, input logic [AVG_W-1:0] a);
      @(posedge clk);
      #5;
      fb_chan = c;
      fb_dither_start = s;
      fb_cycle_avg = a;
      fb_cycle_done = 1'b1;
      @(posedge clk);
      #5;
      fb_cycle_done = 1'b0;
      fb_chan = ~c;
      fb_dither_start = ~s;
      fb_cycle_avg = ~a;
   endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench
   import pwm_pkg::*;
();
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic sel_wr = 1'b0, avg_access = 1'b0, minmax_access = 1'b0, direct_mode = 1'b0;
   logic div_wr = 1'b0, pi_gate = 1'b0, adc_valid = 1'b0, status_read = 1'b0;
   logic [2:0] sel_chan = 3'h0;
   logic [3:0] dither_steps = 4'h0, dither_amp = 4'h0, zone1_required_hits = 4'h3;
   logic [DIV_W-1:0] div_in = 14'h0000;
   logic [1:0] samples_sel = 2'h0, zone3_span = 2'h1;
   logic [DUTY_W-1:0] duty_in = 19'h00000;
   logic [ADC_W-1:0] adc_data = 10'h000;
   logic [15:0] profile_timeout = 16'h0bb8;
   logic [SUM_W-1:0] psum;
   logic [AVG_W-1:0] pmin, pmax, fa;
   logic [DIV_W-1:0] dv[6] = '{14'h0000, 14'h004e, 14'h004f, 14'h0050, 14'h3fff, 14'h009d};
   logic [ADC_W-1:0] ramp[19] = '{10'h064, 10'h06e, 10'h078, 10'h073, 10'h08c, 10'h096,
      10'h0a0, 10'h0aa, 10'h0a0, 10'h096, 10'h08c, 10'h082, 10'h08c, 10'h096, 10'h0a0,
      10'h0aa, 10'h0b4, 10'h0be, 10'h0c8};
   logic [2:0] stat_exp[3] = '{3'h4, 3'h2, 3'h1};
   wire [2:0] fb_chan, sel_chan_rd;
   wire fb_cycle_done, fb_dither_start, avg_valid, minmax_valid, gate_drive_output;
   wire integ_clear, period_start, profile_passed, profile_timed_out, profile_interrupted;
   wire [AVG_W-1:0] fb_cycle_avg;
   wire [SUM_W-1:0] avg_sum;
   wire [MM_W-1:0] min_cur, max_cur;
   wire [DIV_W-1:0] div_rd;
   wire [3:0] profile_zone;
   int errors = 0, checks_done = 0, len, hi;

   always #25 clk = ~clk;

   fb_source i_src (.clk, .fb_chan, .fb_cycle_done, .fb_dither_start, .fb_cycle_avg);
   direct_pwm_profile_detect_feedback i_dut (.clk, .reset, .sel_wr, .sel_chan, .avg_access,
      .minmax_access, .fb_chan, .fb_cycle_done, .fb_dither_start, .fb_cycle_avg,
      .dither_steps, .dither_amp, .sel_chan_rd, .avg_sum, .avg_valid, .min_cur, .max_cur,
      .minmax_valid, .direct_mode, .div_wr, .div_in, .samples_sel, .duty_in, .pi_gate,
      .div_rd, .gate_drive_output, .integ_clear, .period_start, .adc_start(), .adc_valid,
      .adc_data, .zone1_slope_limit(10'h005), .zone2_slope_limit(10'h000),
      .zone3_slope_limit(10'h003), .zone1_required_hits, .zone2_required_hits(4'h2),
      .zone3_required_hits(4'h2), .zone3_span, .profile_timeout, .status_read,
      .profile_zone, .profile_passed, .profile_timed_out, .profile_interrupted);

   // ==========================================
   // helpers
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [SUM_W-1:0] seen, input logic [SUM_W-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask
   task automatic wait_for(input bit ps, input logic lvl);
      int n;
      n = 0;
      while ((ps ? period_start : gate_drive_output) !== lvl && n < 50000) begin
         tick(1);
         n++;
      end
      if (n >= 50000) begin
         errors++;
         $display("[FAIL] wait expected %b seen none", lvl);
         final_report();
      end
   endtask
   // one period holds one on-time, any phase
   task automatic measure();
      wait_for(1'b1, 1'b1);
      len = 0;
      hi = 0;
      do begin
         tick(1);
         len++;
         hi += int'(gate_drive_output === 1'b1);
      end while (period_start !== 1'b1 && len < 50000);
   endtask
   task automatic dstart(input bit check);
      fa = AVG_W'($urandom);
      i_src.send(3'h5, 1'b1, fa);
      if (check) begin
         chk("avg_sum", avg_sum, psum);
         chk("min_cur", min_cur, pmin[12:2]);
         chk("max_cur", max_cur, pmax[12:2]);
         chk("valids", {avg_valid, minmax_valid}, 2'h3);
      end
      psum = SUM_W'(fa);
      pmin = fa;
      pmax = fa;
   endtask
   task automatic dcycles(input int k);
      for (int i = 0; i < k; i++) begin
         fa = (i == 1) ? 13'h1fff : AVG_W'($urandom);
         i_src.send(3'h5, 1'b0, fa);
         i_src.send(3'h2, 1'b1, ~fa);
         psum += SUM_W'(fa);
         pmin = (fa < pmin) ? fa : pmin;
         pmax = (fa > pmax) ? fa : pmax;
      end
   endtask

   // ==========================================
   // main sequence
   initial begin
      void'($urandom(72619));
      tick(20);
      reset = 1'b0;
      chk("div_rd", div_rd, 14'h0271);
      div_wr = 1'b1;
      foreach (dv[i]) begin
         div_in = dv[i];
         tick(1);
         chk("div_rd", div_rd, (dv[i] < 14'h004f) ? 14'h004f : dv[i]);
      end
      div_wr = 1'b0;
      sel_wr = 1'b1;
      sel_chan = 3'h5;
      tick(1);
      sel_wr = 1'b0;
      chk("sel_chan_rd", sel_chan_rd, 3'h5);
      dither_steps = 4'h4;
      dither_amp = 4'h3;
      i_src.send(3'h5, 1'b0, 13'h0abc);
      dstart(1'b0);
      dcycles(3);
      chk("valids", {avg_valid, minmax_valid}, 2'h0);
      dstart(1'b1);
      avg_access = 1'b1;
      minmax_access = 1'b1;
      tick(1);
      avg_access = 1'b0;
      minmax_access = 1'b0;
      chk("valids", {avg_valid, minmax_valid}, 2'h0);
      dcycles(40);
      dstart(1'b1);
      for (int i = 0; i < 4; i++) begin
         dither_steps = i[0] ? 4'h0 : 4'h6;
         dither_amp = i[0] ? 4'h2 : 4'h0;
         fa = (i == 3) ? 13'h1fff : AVG_W'($urandom);
         i_src.send(3'h5, 1'b0, fa);
         chk("avg_sum", avg_sum, SUM_W'(fa));
         chk("min max", {min_cur, max_cur}, {fa[12:2], fa[12:2]});
      end
      // divider 157 keeps the sample rate at 127.4 kHz
      direct_mode = 1'b1;
      pi_gate = 1'b1;
      duty_in = DUTY_W'($urandom_range(2000, 200));
      for (int s = 0; s < 2; s++) begin
         samples_sel = s[1:0];
         measure();
         measure();
         chk("period", len, (32 << s) * 157);
         chk("on_time", hi, int'(duty_in) * (32 << s) / 32);
         chk("integ_clear", integ_clear, 1'b1);
      end
      duty_in = 19'h7ffff;
      measure();
      measure();
      chk("clipped", hi, len);
      duty_in = 19'h003e8;
      for (int k = 0; k < 3; k++) begin
         profile_timeout = (k == 2) ? 16'h00c8 : 16'h0bb8;
         status_read = 1'b1;
         tick(1);
         status_read = 1'b0;
         wait_for(1'b0, 1'b0);
         wait_for(1'b0, 1'b1);
         for (int i = 0; i < 19 && k == 0; i++) begin
            adc_data = ramp[i];
            adc_valid = 1'b1;
            tick(1);
            adc_valid = 1'b0;
            tick(3);
         end
         wait_for(1'b0, 1'b0);
         tick(3);
         chk("status", {profile_passed, profile_interrupted, profile_timed_out}, stat_exp[k]);
      end
      direct_mode = 1'b0;
      tick(3);
      chk("zone idle", profile_zone, 4'h1);
      chk("integ_clear", integ_clear, 1'b0);
      final_report();
   end
endmodule
